// ==== hdl/serial_config_loader.sv ====
// configuration loader: active flash read, passive and jtag shift-in, user flash port
// assumes clk_link is the internal oscillator; straps stay still while loading
// What this block does
// - flash holds 16 Mbit; its clock never runs above 20 MHz
// - with a good bitstream, active loading starts alone after power-up
// - flash holds two images side by side
// - bitstream words are written into the config memory cells before user mode
// - active mode flash clock comes from the internal oscillator
// - active loading first sends the wake from power-down command
// - wait at least 30 us, then fast read from address zero, or from 24'h100000 when imageSel picks the second image
// - passive mode: outside master supplies clock, control and data
// - configuration through jtag, one bit wide
// - active mode x1, x2, x4; passive up to x32
// - large package: no multi-image active load at x1
`default_nettype none
`include "scl_regs.svh"

module serial_config_loader #(
   parameter int IMAGE_WORDS = `SCL_IMAGE_WORDS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_link,
   input wire logic configResetLow,
   input wire logic [1:0] modeSel,
   input wire logic [2:0] widthSel,
   input wire logic largePkg,
   input wire logic imageSel,
   input wire logic pasClk,
   input wire logic [31:0] pasData,
   input wire logic jtagTck,
   input wire logic jtagTdi,
   input wire logic [3:0] flashIoIn,
   input wire logic lvdsTxUsed,
   input wire logic usrSclk,
   input wire logic usrMosi,
   input wire logic usrWpLow,
   input wire logic usrHoldLow,
   input wire logic usrCsLow,
   output logic flashSclk_q,
   output logic flashCsLow_q,
   output logic [3:0] flashIoOut_q,
   output logic [3:0] flashIoOeLow_q,
   output logic cellWrEn_q,
   output logic [18:0] cellAddr_q,
   output logic [31:0] cellData_q,
   output logic configDone_q,
   output logic configError_q,
   output logic usrMiso_q
);

   localparam int PW = 44;
   localparam logic [9:0] WAIT_LAST = 10'(`SCL_WAKE_WAIT_CYC - 1);
   localparam logic [18:0] LAST_WORD = 19'(IMAGE_WORDS - 1);

   function automatic logic [31:0] sclShift(
      input logic [31:0] a,
      input logic [31:0] d,
      input scl_pkg::scl_width_type w
   );
      case (w)
         scl_pkg::SCL_W1: sclShift = {a[30:0], d[0]};
         scl_pkg::SCL_W2: sclShift = {a[29:0], d[1:0]};
         scl_pkg::SCL_W4: sclShift = {a[27:0], d[3:0]};
         scl_pkg::SCL_W8: sclShift = {a[23:0], d[7:0]};
         scl_pkg::SCL_W16: sclShift = {a[15:0], d[15:0]};
         default: sclShift = d;
      endcase
   endfunction

   // ****************************************
   // pin synchronisers, system side
   // ****************************************
   logic [PW-1:0] pinIn;
   logic [PW-1:0] s1Q;
   logic [PW-1:0] s2Q;
   logic [PW-1:0] s3Q;
   logic [PW-1:0] pinQ;
   logic [PW-1:0] prevQ;

   assign pinIn = {flashIoIn[1], imageSel, largePkg, widthSel, modeSel,
                   configResetLow, jtagTdi, jtagTck, pasClk, pasData};

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1Q <= '0;
         s2Q <= '0;
         s3Q <= '0;
         prevQ <= '0;
      end else begin
         s1Q <= pinIn;
         s2Q <= s1Q;
         s3Q <= s2Q;
         prevQ <= pinQ;
      end
   end

   // a level counts only once two stages agree
   for (genvar i = 0; i < PW; i++) begin : g_pin
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            pinQ[i] <= 1'b0;
         end else if (s2Q[i] == s3Q[i]) begin
            pinQ[i] <= s3Q[i];
         end
      end
   end

   // ****************************************
   // load control, system side
   // ****************************************
   logic startEv;
   logic pasRise;
   logic tckRise;
   logic badCfg;
   logic lastWr;
   logic runQ;
   logic imgQ;
   logic usrEnQ;
   scl_pkg::scl_mode_type pinMode;
   scl_pkg::scl_width_type pinWidth;
   scl_pkg::scl_mode_type modeQ;
   scl_pkg::scl_width_type widthQ;

   assign pinMode = scl_pkg::scl_mode_type'(pinQ[37:36]);
   assign pinWidth = scl_pkg::scl_width_type'(pinQ[40:38]);
   // reset value low makes a released pin look like a rising edge after power-up
   assign startEv = pinQ[35] & ~prevQ[35];
   assign pasRise = pinQ[32] & ~prevQ[32];
   assign tckRise = pinQ[33] & ~prevQ[33];
   assign badCfg = (pinMode == scl_pkg::SCL_MODE_NONE) ||
                   (pinWidth > scl_pkg::SCL_W32) ||
                   (pinMode == scl_pkg::SCL_MODE_ACTIVE && pinWidth > scl_pkg::SCL_W4) ||
                   (pinMode == scl_pkg::SCL_MODE_ACTIVE && pinQ[41] && pinQ[42] &&
                    pinWidth == scl_pkg::SCL_W1);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         runQ <= 1'b0;
         configDone_q <= 1'b0;
         configError_q <= 1'b0;
         modeQ <= scl_pkg::SCL_MODE_NONE;
         widthQ <= scl_pkg::SCL_W1;
         imgQ <= 1'b0;
      end else if (startEv) begin
         modeQ <= pinMode;
         widthQ <= pinWidth;
         imgQ <= pinQ[42];
         configDone_q <= 1'b0;
         configError_q <= badCfg;
         runQ <= ~badCfg;
      end else if (!pinQ[35]) begin
         runQ <= 1'b0;
         configDone_q <= 1'b0;
      end else if (lastWr) begin
         runQ <= 1'b0;
         configDone_q <= 1'b1;
      end
   end

   // user port drives the flash only once loaded and with the transmitters idle; miso always follows flash io1
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         usrEnQ <= 1'b0;
         usrMiso_q <= 1'b0;
      end else begin
         usrEnQ <= configDone_q & ~lvdsTxUsed;
         usrMiso_q <= pinQ[43];
      end
   end

   // ****************************************
   // word assembly and cell writes
   // ****************************************
   logic [31:0] accSysQ;
   logic [31:0] sysNext;
   logic [5:0] fillSysQ;
   logic [5:0] sysStep;
   logic sysShiftEv;
   logic sysWordEv;
   logic linkWordEv;
   logic reqS1Q;
   logic reqS2Q;
   logic ackTogQ;
   logic reqTogQ;
   logic [31:0] holdQ;
   logic [18:0] wordCntQ;
   scl_pkg::scl_width_type sysW;

   assign sysW = (modeQ == scl_pkg::SCL_MODE_JTAG) ? scl_pkg::SCL_W1 : widthQ;
   assign sysStep = 6'h01 << sysW;
   // outside master owns the pace here; its post reset delay is not checked
   assign sysShiftEv = runQ && ((modeQ == scl_pkg::SCL_MODE_PASSIVE && pasRise) ||
                                (modeQ == scl_pkg::SCL_MODE_JTAG && tckRise));
   assign sysNext = (modeQ == scl_pkg::SCL_MODE_JTAG) ? sclShift(accSysQ, 32'(pinQ[34]), sysW) :
                    sclShift(accSysQ, pinQ[31:0], sysW);
   assign sysWordEv = sysShiftEv && (6'(fillSysQ + sysStep) == 6'h20);
   assign linkWordEv = reqS2Q != ackTogQ;
   assign lastWr = runQ && (sysWordEv || linkWordEv) && wordCntQ == LAST_WORD;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         accSysQ <= 32'h00000000;
         fillSysQ <= 6'h00;
      end else if (startEv) begin
         fillSysQ <= 6'h00;
      end else if (sysShiftEv) begin
         accSysQ <= sysNext;
         fillSysQ <= sysWordEv ? 6'h00 : 6'(fillSysQ + sysStep);
      end
   end

   // acknowledge even after an abort so the link never hangs on a word
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reqS1Q <= 1'b0;
         reqS2Q <= 1'b0;
         ackTogQ <= 1'b0;
      end else begin
         reqS1Q <= reqTogQ;
         reqS2Q <= reqS1Q;
         ackTogQ <= reqS2Q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cellWrEn_q <= 1'b0;
         cellAddr_q <= 19'h00000;
         cellData_q <= 32'h00000000;
         wordCntQ <= 19'h00000;
      end else begin
         cellWrEn_q <= 1'b0;
         if (startEv) begin
            wordCntQ <= 19'h00000;
         end else if (runQ && (sysWordEv || linkWordEv)) begin
            cellWrEn_q <= 1'b1;
            cellData_q <= linkWordEv ? holdQ : sysNext;
            cellAddr_q <= wordCntQ;
            wordCntQ <= wordCntQ + 19'h00001;
         end
      end
   end

   // ****************************************
   // crossings into the link domain
   // ****************************************
   logic [11:0] lkIn;
   logic [11:0] lkS1Q;
   logic [11:0] lkS2Q;
   logic go;
   logic lkUsr;
   logic lkImg;
   scl_pkg::scl_width_type lkW;

   assign lkIn = {imgQ, widthQ, usrCsLow, usrHoldLow, usrWpLow, usrMosi, usrSclk,
                  usrEnQ, ackTogQ, runQ};
   assign go = lkS2Q[0];
   assign lkUsr = lkS2Q[2];
   assign lkW = scl_pkg::scl_width_type'(lkS2Q[10:8]);
   assign lkImg = lkS2Q[11];

   always_ff @(posedge clk_link or negedge rst_n) begin
      if (!rst_n) begin
         lkS1Q <= 12'h000;
         lkS2Q <= 12'h000;
      end else begin
         lkS1Q <= lkIn;
         lkS2Q <= lkS1Q;
      end
   end

   // ****************************************
   // flash sequencer, link domain
   // ****************************************
   scl_pkg::scl_link_type lkState;
   logic phQ;
   logic pendQ;
   logic [4:0] bitCntQ;
   logic [31:0] shQ;
   logic [9:0] waitCntQ;
   logic shifting;
   logic rise;
   logic fall;
   logic lastBit;
   logic [7:0] readOp;
   logic [23:0] readAddr;

   assign shifting = lkState != scl_pkg::LK_IDLE && lkState != scl_pkg::LK_WAIT;
   // flash clock is the oscillator halved, about 10.4 MHz
   assign rise = shifting && !phQ && !pendQ;
   assign fall = shifting && phQ;
   assign lastBit = fall && bitCntQ == 5'h00;
   assign readOp = (lkW == scl_pkg::SCL_W4) ? `SCL_OP_READ_X4 :
                   (lkW == scl_pkg::SCL_W2) ? `SCL_OP_READ_X2 : `SCL_OP_READ_X1;
   assign readAddr = lkImg ? `SCL_IMAGE1_ADDR : `SCL_START_ADDR;

   always_ff @(posedge clk_link or negedge rst_n) begin
      if (!rst_n) begin
         lkState <= scl_pkg::LK_IDLE;
         phQ <= 1'b0;
         bitCntQ <= 5'h00;
         shQ <= 32'h00000000;
         waitCntQ <= 10'h000;
         flashSclk_q <= 1'b0;
         flashCsLow_q <= 1'b1;
         flashIoOut_q <= 4'h0;
         flashIoOeLow_q <= 4'hF;
      end else begin
         if (rise) begin
            phQ <= 1'b1;
            flashSclk_q <= 1'b1;
         end
         if (fall) begin
            phQ <= 1'b0;
            flashSclk_q <= 1'b0;
            bitCntQ <= bitCntQ - 5'h01;
            shQ <= {shQ[30:0], 1'b0};
            flashIoOut_q[0] <= shQ[30];
         end
         if (!go && lkState != scl_pkg::LK_IDLE) begin
            lkState <= scl_pkg::LK_IDLE;
            phQ <= 1'b0;
            flashSclk_q <= 1'b0;
            flashCsLow_q <= 1'b1;
            flashIoOeLow_q <= 4'hF;
         end else begin
            case (lkState)
               scl_pkg::LK_IDLE: begin
                  if (go) begin
                     lkState <= scl_pkg::LK_WAKE;
                     shQ <= {`SCL_OP_WAKE, 24'h000000};
                     bitCntQ <= 5'h07;
                     phQ <= 1'b0;
                     flashSclk_q <= 1'b0;
                     flashCsLow_q <= 1'b0;
                     flashIoOut_q <= {3'h6, 1'(`SCL_OP_WAKE >> 7)};
                     flashIoOeLow_q <= 4'h2;
                  end else if (lkUsr) begin
                     flashSclk_q <= lkS2Q[3];
                     flashCsLow_q <= lkS2Q[7];
                     flashIoOut_q <= {lkS2Q[6], lkS2Q[5], 1'b0, lkS2Q[4]};
                     flashIoOeLow_q <= 4'h2;
                  end else begin
                     flashSclk_q <= 1'b0;
                     flashCsLow_q <= 1'b1;
                     flashIoOut_q <= 4'h0;
                     flashIoOeLow_q <= 4'hF;
                  end
               end
               scl_pkg::LK_WAKE: begin
                  if (lastBit) begin
                     lkState <= scl_pkg::LK_WAIT;
                     flashCsLow_q <= 1'b1;
                     waitCntQ <= 10'h000;
                  end
               end
               scl_pkg::LK_WAIT: begin
                  if (waitCntQ == WAIT_LAST) begin
                     lkState <= scl_pkg::LK_CMD;
                     shQ <= {readOp, readAddr};
                     bitCntQ <= 5'h1F;
                     flashCsLow_q <= 1'b0;
                     flashIoOut_q[0] <= readOp[7];
                  end else begin
                     waitCntQ <= waitCntQ + 10'h001;
                  end
               end
               scl_pkg::LK_CMD: begin
                  if (lastBit) begin
                     lkState <= scl_pkg::LK_DUMMY;
                     bitCntQ <= 5'(`SCL_DUMMY_CYC - 1);
                     flashIoOeLow_q <= (lkW == scl_pkg::SCL_W4) ? 4'hF :
                                       (lkW == scl_pkg::SCL_W2) ? 4'h3 : 4'h2;
                  end
               end
               scl_pkg::LK_DUMMY: begin
                  if (lastBit) begin
                     lkState <= scl_pkg::LK_READ;
                  end
               end
               scl_pkg::LK_READ: begin
                  lkState <= scl_pkg::LK_READ;
               end
               default: begin
                  lkState <= scl_pkg::LK_IDLE;
               end
            endcase
         end
      end
   end

   // ****************************************
   // read data and word handshake, link domain
   // ****************************************
   logic [31:0] accQ;
   logic [5:0] fillQ;
   logic [5:0] lkStep;
   logic [31:0] lkData;

   assign lkStep = 6'h01 << lkW;
   assign lkData = (lkW == scl_pkg::SCL_W1) ? 32'(flashIoIn[1]) : 32'(flashIoIn);

   // clock stalls while a word waits, so the flash never outruns the cells
   always_ff @(posedge clk_link or negedge rst_n) begin
      if (!rst_n) begin
         accQ <= 32'h00000000;
         fillQ <= 6'h00;
         pendQ <= 1'b0;
         holdQ <= 32'h00000000;
         reqTogQ <= 1'b0;
      end else begin
         if (lkState != scl_pkg::LK_READ) begin
            fillQ <= 6'h00;
            pendQ <= 1'b0;
         end else if (rise) begin
            accQ <= sclShift(accQ, lkData, lkW);
            if (6'(fillQ + lkStep) == 6'h20) begin
               fillQ <= 6'h00;
               pendQ <= 1'b1;
            end else begin
               fillQ <= 6'(fillQ + lkStep);
            end
         end
         if (pendQ && reqTogQ == lkS2Q[1]) begin
            holdQ <= accQ;
            reqTogQ <= ~reqTogQ;
            pendQ <= 1'b0;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence wakeStart;
      lkState == scl_pkg::LK_IDLE ##1 lkState == scl_pkg::LK_WAKE;
   endsequence

   sequence cmdStart;
      lkState == scl_pkg::LK_WAIT ##1 lkState == scl_pkg::LK_CMD;
   endsequence

   flash_clk_div_a: assert property (@(posedge clk_link) disable iff (!rst_n)
      (flashSclk_q && lkState != scl_pkg::LK_IDLE) |=> !flashSclk_q)
      else $error("flash clock high two cycles");
   wake_first_a: assert property (@(posedge clk_link) disable iff (!rst_n)
      wakeStart |-> shQ[31:24] == `SCL_OP_WAKE && !flashCsLow_q)
      else $error("load did not open with wake");
   wake_wait_a: assert property (@(posedge clk_link) disable iff (!rst_n)
      cmdStart |-> $past(waitCntQ) == WAIT_LAST) else $error("wake wait too short");
   read_addr_a: assert property (@(posedge clk_link) disable iff (!rst_n)
      cmdStart |-> shQ[23:0] == readAddr && !flashCsLow_q) else $error("bad read address");
   read_opcode_a: assert property (@(posedge clk_link) disable iff (!rst_n)
      cmdStart |-> shQ[31:24] == readOp) else $error("read opcode does not match width");
   msb_first_a: assert property (@(posedge clk_link) disable iff (!rst_n)
      (lkState == scl_pkg::LK_CMD && fall && go) |=> flashIoOut_q[0] == $past(shQ[30]))
      else $error("command not shifted msb first");
   usr_cs_a: assert property (@(posedge clk_link) disable iff (!rst_n)
      (lkState == scl_pkg::LK_IDLE && !go && lkUsr) |=> flashCsLow_q == $past(lkS2Q[7]))
      else $error("user chip select not passed");
   auto_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (startEv && !badCfg) |=> runQ && !configError_q) else $error("load did not start");
   multi_img_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (startEv && pinMode == scl_pkg::SCL_MODE_ACTIVE && pinQ[41] && pinQ[42] &&
       pinWidth == scl_pkg::SCL_W1) |=> configError_q && !runQ)
      else $error("x1 multi-image accepted");
   cell_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (runQ && linkWordEv && !startEv) |=> cellWrEn_q && cellData_q == $past(holdQ))
      else $error("flash word not written");
   passive_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sysShiftEv && modeQ == scl_pkg::SCL_MODE_PASSIVE && widthQ == scl_pkg::SCL_W32)
      |=> cellWrEn_q && cellData_q == $past(pinQ[31:0])) else $error("passive word lost");
   jtag_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (sysShiftEv && modeQ == scl_pkg::SCL_MODE_JTAG) |=> accSysQ[0] == $past(pinQ[34]))
      else $error("jtag bit not shifted");

endmodule

`default_nettype wire

// ==== hdl/scl_regs.svh ====
// timing, opcode and sizing constants of the serial configuration loader
// assumes inclusion by bare name from the hdl folder
`ifndef SCL_REGS_SVH
`define SCL_REGS_SVH

// flash size and clock ceiling
`define SCL_FLASH_MBIT 16
`define SCL_FLASH_MAX_MHZ 20
`define SCL_SYS_PERIOD_NS 10
`define SCL_LINK_PERIOD_NS 48
`define SCL_LINK_DIV 2

// wake wait, rounded up to whole link cycles
`define SCL_WAKE_WAIT_US 30
`define SCL_WAKE_WAIT_CYC ((`SCL_WAKE_WAIT_US * 1000 + `SCL_LINK_PERIOD_NS - 1) / `SCL_LINK_PERIOD_NS)

// flash opcodes, sent msb first
`define SCL_OP_WAKE 8'hAB
`define SCL_OP_READ_X1 8'h0B
`define SCL_OP_READ_X2 8'h3B
`define SCL_OP_READ_X4 8'h6B
`define SCL_DUMMY_CYC 8

// image placement, two images of half the flash each
`define SCL_START_ADDR 24'h000000
`define SCL_IMAGE1_ADDR 24'h100000
`define SCL_IMAGE_WORDS 262144

`endif

// ==== hdl/scl_pkg.sv ====
// types of the serial configuration loader
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package scl_pkg;

   typedef enum logic [1:0] {
      SCL_MODE_ACTIVE,
      SCL_MODE_PASSIVE,
      SCL_MODE_JTAG,
      SCL_MODE_NONE
   } scl_mode_type;

   typedef enum logic [2:0] {SCL_W1, SCL_W2, SCL_W4, SCL_W8, SCL_W16, SCL_W32} scl_width_type;

   typedef enum logic [2:0] {LK_IDLE, LK_WAKE, LK_WAIT, LK_CMD, LK_DUMMY, LK_READ} scl_link_type;

endpackage

`default_nettype wire

// ==== test/scl_flash_model.sv ====
// serial flash model: records wake and read frames, streams image words
// assumes loader clock, select and io pins wired straight to it
`default_nettype none
// ****
// flash model
// ****
module scl_flash_model (
   input wire logic sclk,
   input wire logic csLow,
   input wire logic [3:0] ioOut,
   input wire logic [2:0] bitsPer,
   output var logic [3:0] ioIn,
   output var logic [31:0] hdr,
   output var logic [7:0] prevOp,
   output var real gapNs,
   output var real minPer
);
   timeunit 1ns;
   timeprecision 1ps;
   int bitCnt = 0;
   int dIdx = 0;
   int b;
   real riseT = 0.0;
   real lastEdge = 0.0;
   logic [31:0] wd;
   logic [31:0] v;
   initial begin
      ioIn = 4'h5;
      hdr = 32'h0;
      minPer = 1.0e9;
   end
   always @(negedge csLow) begin
      prevOp <= hdr[7:0];
      gapNs <= $realtime - riseT;
      bitCnt <= 0;
      dIdx <= 0;
   end
   // released bus shows the inverse, not the last value
   always @(posedge csLow) begin
      riseT = $realtime;
      ioIn <= ~ioIn;
   end
   always @(posedge sclk) begin
      if ($realtime - lastEdge < minPer) minPer = $realtime - lastEdge;
      lastEdge = $realtime;
      if (!csLow && bitCnt < 32) hdr <= {hdr[30:0], ioOut[0]};
      if (!csLow) bitCnt <= bitCnt + 1;
   end
   // data after opcode, address and 8 dummy clocks, earlier bits on upper io
   always @(negedge sclk) begin
      if (!csLow && bitCnt >= 40) begin
         b = dIdx * bitsPer;
         wd = 32'hC3A50F00 ^ {4{8'(b / 32)}};
         v = (wd << (b % 32)) >> (32 - bitsPer);
         ioIn <= bitsPer == 1 ? {2'h3, v[0], ~v[0]} : bitsPer == 2 ? {2'h3, v[1:0]} : v[3:0];
         dIdx <= dIdx + 1;
      end
   end
endmodule
`default_nettype wire

// ==== test/serial_config_loader_tb_top.sv ====
// bench of the configuration loader: straps, passive and jtag feed, user port
// assumes scl_regs.svh on the include path and the flash model beside it
`default_nettype none
`include "scl_regs.svh"
// ****
// bench top
// ****
module serial_config_loader_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IW = 8;
   localparam int PostResetDelay = 40;
   logic clk_sys = 1'b0, clk_link = 1'b0, rst_n = 1'b0, configResetLow = 1'b1;
   logic largePkg = 1'b0, imageSel = 1'b0, pasClk = 1'b0, jtagTck = 1'b0, jtagTdi = 1'b0;
   logic lvdsTxUsed = 1'b0, usrSclk = 1'b0, usrMosi = 1'b0;
   logic usrWpLow = 1'b1, usrHoldLow = 1'b1, usrCsLow = 1'b1;
   logic [1:0] modeSel = 2'h0;
   logic [2:0] widthSel = 3'h0, bitsPer = 3'h1;
   logic [31:0] pasData = 32'h0, hdr, cellData_q;
   logic [3:0] flashIoIn, flashIoOut_q, flashIoOeLow_q;
   logic flashSclk_q, flashCsLow_q, cellWrEn_q, configDone_q, configError_q, usrMiso_q;
   logic [18:0] cellAddr_q;
   logic [7:0] prevOp;
   real gapNs, minPer;
   int err_total = 0, comparisons = 0, wrCount = 0, cycles = 0;
   serial_config_loader #(.IMAGE_WORDS(IW)) i_serial_config_loader (.clk_sys, .rst_n,
      .clk_link, .configResetLow, .modeSel, .widthSel, .largePkg, .imageSel, .pasClk,
      .pasData, .jtagTck, .jtagTdi, .flashIoIn, .lvdsTxUsed, .usrSclk, .usrMosi,
      .usrWpLow, .usrHoldLow, .usrCsLow, .flashSclk_q, .flashCsLow_q, .flashIoOut_q,
      .flashIoOeLow_q, .cellWrEn_q, .cellAddr_q, .cellData_q, .configDone_q,
      .configError_q, .usrMiso_q);
   scl_flash_model i_scl_flash_model (.sclk(flashSclk_q), .csLow(flashCsLow_q),
      .ioOut(flashIoOut_q), .bitsPer, .ioIn(flashIoIn), .hdr, .prevOp, .gapNs, .minPer);
   initial forever #5 clk_sys = ~clk_sys;
   initial begin
      #7;
      forever #24 clk_link = ~clk_link;
   end
   function automatic logic [31:0] wordOf(input int k);
      return 32'hC3A50F00 ^ {4{8'(k)}};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cellWrEn_q === 1'b1) begin
         check(cellData_q, wordOf(int'(cellAddr_q)));
         wrCount++;
      end
      if (cycles == 60000) begin
         err_total++;
         $display("unexpected at %0t: run timed out", $time);
         conclude();
      end
   end
   task automatic start(input logic [1:0] m, input logic [2:0] w, input logic img);
      modeSel <= m;
      widthSel <= w;
      imageSel <= img;
      configResetLow <= 1'b0;
      repeat (8) @(posedge clk_sys);
      configResetLow <= 1'b1;
      wrCount = 0;
   endtask
   // old error flag stands until the filtered edge lands; done already cleared on the filtered low
   task automatic finish_load(input logic err);
      repeat (8) @(posedge clk_sys);
      for (int i = 0; i < 20000 && configDone_q !== 1'b1 && configError_q !== 1'b1; i++)
         @(posedge clk_sys);
      repeat (2) @(posedge clk_sys);
      check(configError_q, err);
      check(configDone_q, !err);
      check(wrCount, err ? 0 : IW);
   endtask
   task automatic active_chk(input logic [2:0] w, input logic img);
      finish_load(1'b0);
      check(prevOp, `SCL_OP_WAKE);
      check(hdr[31:24], w == 0 ? `SCL_OP_READ_X1 : w == 1 ? `SCL_OP_READ_X2 : `SCL_OP_READ_X4);
      check(hdr[23:0], img ? `SCL_IMAGE1_ADDR : `SCL_START_ADDR);
      check(gapNs >= 30000.0, 1'b1);
      check(minPer >= 96.0, 1'b1);
      $display("active load x%0d image %0d done", 1 << w, img);
   endtask
   task automatic strap_test();
      start(2'h0, 3'h3, 1'b0);
      finish_load(1'b1);
      largePkg <= 1'b1;
      start(2'h0, 3'h0, 1'b1);
      finish_load(1'b1);
      largePkg <= 1'b0;
      start(2'h3, 3'h0, 1'b0);
      finish_load(1'b1);
      start(2'h1, 3'h6, 1'b0);
      finish_load(1'b1);
      $display("strap refusal test done");
   endtask
   task automatic shift_test(input logic [1:0] m, input int w);
      logic [63:0] c;
      start(m, m == 2'h2 ? 3'h0 : 3'($clog2(w)), 1'b0);
      repeat (PostResetDelay) @(posedge clk_sys);
      for (int k = 0; k < IW; k++)
         for (int s = 0; s < 32 / w; s++) begin
            c = ({32'h0, wordOf(k)} >> (32 - w * (s + 1))) & ((64'h1 << w) - 1);
            pasData <= c[31:0];
            jtagTdi <= c[0];
            repeat (5) @(posedge clk_sys);
            jtagTck <= 1'b1;
            pasClk <= 1'b1;
            repeat (5) @(posedge clk_sys);
            jtagTck <= 1'b0;
            pasClk <= 1'b0;
         end
      finish_load(1'b0);
      $display("shift load mode %0d width %0d done", m, w);
   endtask
   task automatic user_test();
      for (int v = 0; v < 2; v++) begin
         usrCsLow <= 1'b0;
         usrMosi <= v[0];
         usrWpLow <= ~v[0];
         usrHoldLow <= v[0];
         usrSclk <= v[0];
         repeat (30) @(posedge clk_sys);
         check(flashCsLow_q, 1'b0);
         check(flashSclk_q, v[0]);
         check(flashIoOut_q[0], v[0]);
         check(flashIoOut_q[3:2], {v[0], ~v[0]});
         check(flashIoOeLow_q, 4'h2);
         check(usrMiso_q, flashIoIn[1]);
      end
      lvdsTxUsed <= 1'b1;
      repeat (30) @(posedge clk_sys);
      check(flashCsLow_q, 1'b1);
      $display("user flash port test done");
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      active_chk(3'h0, 1'b0);
      for (int w = 1; w < 3; w++) begin
         bitsPer <= 3'(1 << w);
         start(2'h0, 3'(w), w == 2);
         active_chk(3'(w), w == 2);
      end
      strap_test();
      shift_test(2'h1, 32);
      shift_test(2'h1, 8);
      shift_test(2'h1, 16);
      shift_test(2'h2, 1);
      user_test();
      conclude();
   end
endmodule
`default_nettype wire
